/* sctc_ctrl.sv */
// Synthesizer calibration test control registers with calibration sequencer.
`timescale 1ns/100ps
module sctc_ctrl (
    input  wire logic              sys_clk_in,        // 125 MHz clock.
    input  wire logic              reset_n_in,        // Asynchronous active-low reset.
    input  wire sctc_pkg::sctc_wr_s cfg_wr_in,        // Register write request.
    input  wire logic [5:0]        cfg_raddr_in,      // Register read index.
    input  wire logic              rx_entry_in,       // Pulse on entry to receive.
    input  wire logic              tx_entry_in,       // Pulse on entry to transmit.
    input  wire logic              tx_cal_strobe_in,  // Transmit-calibrate strobe.
    input  wire logic              vco_freq_high_in,  // Comparator: oscillator above target.
    input  wire logic              bias_high_in,      // Comparator: bias above reference.
    output logic [15:0]            cfg_rdata_out,     // Read data, registered.
    output logic [4:0]             mid_to_high_gain_delta_out, // Gain delta mid to high.
    output logic [4:0]             low_to_mid_gain_delta_out,  // Gain delta low to mid.
    output logic [4:0]             osc_array_out,     // Array setting to the oscillator.
    output logic [5:0]             osc_bias_a_out,    // First bias current.
    output logic [5:0]             osc_bias_b_out,    // Second bias current or constant.
    output logic [3:0]             osc_bias_reference_out, // Bias reference code.
    output logic [1:0]             osc_bias_cal_speed_out, // Bias calibration speed.
    output logic                   tune_node_dac_select_out, // High selects the dac.
    output logic [2:0]             tune_node_dac_value_out,  // Tune dac value.
    output logic                   cal_busy_out,      // Calibration running.
    output logic                   pump_enable_out,   // Charge pump enabled.
    output logic                   pump_pulse_mask_out, // Masks detector pulses.
    output logic                   pump_force_up_out, // Force up current.
    output logic                   pump_force_down_out, // Force down current.
    output logic                   phase_det_long_delay_out, // Long reset delay.
    output logic [3:0]             pump_current_out   // Charge pump current code.
);
    sctc_pkg::sctc_state_s s_q;  // Registered state.
    sctc_pkg::sctc_state_s s_d;  // Next state.
    logic rst_n;                 // Synchronised reset.
    logic start_cal;             // Calibration start request.
    logic [13:0] cal_len;        // Total calibration length in cycles.
    logic [4:0]  settle_len;     // Settling length per array step.
    logic [8:0]  step_len;       // Ramp step length in cycles.

    // Reset is released through two flops so release is synchronous.
    // The two flops live in the state struct and are clocked by the one
    // state process below, so the struct keeps a single driver.
    // Assertion of reset stays asynchronous; only its release is timed.
    // While the second flop is still low the sequencer is held idle and
    // register writes are ignored, so software must wait two edges.
    assign rst_n = s_q.rst_sync[1];

    // Ramp interval decode shared by the ramp counter.
    // The step periods are whole clock cycles, so the shortest interval
    // is a quarter of a cycle short of its nominal length at this clock.
    // That small shortfall was accepted rather than adding a fractional
    // accumulator that would only matter for the two fastest settings.
    function automatic logic [8:0] step_cycles(input logic [1:0] sel);
        case (sel)
            2'd0:    step_cycles = 9'(sctc_pkg::STEP0_CYC);
            2'd1:    step_cycles = 9'(sctc_pkg::STEP1_CYC);
            2'd2:    step_cycles = 9'(sctc_pkg::STEP2_CYC);
            default: step_cycles = 9'(sctc_pkg::STEP3_CYC);
        endcase
    endfunction

    // Calibration starts on every entry, or rx only when tx skip is set.
    // The strobe always starts a calibration, whatever the skip bit says.
    // Entry pulses are single cycles from logic on this clock, so they
    // need no synchroniser and are read directly.
    assign start_cal = rx_entry_in | tx_cal_strobe_in
                     | (tx_entry_in & ~s_q.cfg[15]);
    assign cal_len = s_q.cfg[14] ? 14'(sctc_pkg::CAL_LONG_CYC)
                                 : 14'(sctc_pkg::CAL_SHORT_CYC);
    // The doubled settle covers slow array switching at low supply.
    // Both lengths are the last count of the window, hence the minus one.
    // Doubling the window must not overflow the five-bit settle counter.
    assign settle_len = s_q.arr[11] ? 5'(2 * sctc_pkg::SETTLE_CYC - 1)
                                    : 5'(sctc_pkg::SETTLE_CYC - 1);
    // The step length is decoded once and used by the ramp branch only.
    assign step_len = step_cycles(s_q.pump[9:8]);

    // Next-state logic: register writes, calibration and ramp.
    // Register writes come first so that a write in the same cycle as a
    // sequencer step still lands; the sequencer never changes registers.
    // Result fields are owned by the sequencer and cannot be written.
    // Only one process computes the next state, which keeps every field
    // of the struct driven from one place.
    always_comb begin
        s_d = s_q;
        // Writes mask reserved bits; software is expected to write zeros there.
        if (cfg_wr_in.wr) begin
            case (cfg_wr_in.addr)
                sctc_pkg::ADDR_GAIN_DIFF:  s_d.gain = cfg_wr_in.data & sctc_pkg::WMASK_GAIN;
                sctc_pkg::ADDR_ARRAY_TEST: s_d.arr = cfg_wr_in.data & sctc_pkg::WMASK_ARRAY;
                sctc_pkg::ADDR_CAL_CFG:    s_d.cfg = cfg_wr_in.data;
                sctc_pkg::ADDR_BIAS_TEST:  s_d.bias = cfg_wr_in.data & sctc_pkg::WMASK_BIAS;
                sctc_pkg::ADDR_PUMP_TEST:  s_d.pump = cfg_wr_in.data;
                default: ;
            endcase
        end
        case (s_q.st)
            sctc_pkg::SCTC_IDLE: begin
                // Idle waits for a start and keeps the last results.
                // The array search restarts from mid scale on a start from idle only.
                if (start_cal) begin
                    s_d.st = sctc_pkg::SCTC_CAL;
                    s_d.cal_cnt = 14'h0000;
                    s_d.settle_cnt = 5'h00;
                    s_d.arr_res = sctc_pkg::RST_ARRAY_RES;
                end
            end
            sctc_pkg::SCTC_CAL: begin
                // Calibration runs for a fixed length; starts are ignored.
                // The search is a simple one-step walk per settle window.
                // A walk is slower than a binary search but never overshoots
                // when the comparator output is noisy near the target.
                s_d.cal_cnt = s_q.cal_cnt + 14'h0001;
                // One-step walk of both results after each settle window.
                if (s_q.settle_cnt >= settle_len) begin
                    s_d.settle_cnt = 5'h00;
                    if (vco_freq_high_in && s_q.arr_res != 5'h1f) begin
                        s_d.arr_res = s_q.arr_res + 5'h01;
                    end else if (!vco_freq_high_in && s_q.arr_res != 5'h00) begin
                        s_d.arr_res = s_q.arr_res - 5'h01;
                    end
                    if (bias_high_in && s_q.bias_res != 6'h00) begin
                        s_d.bias_res = s_q.bias_res - 6'h01;
                    end else if (!bias_high_in && s_q.bias_res != 6'h3f) begin
                        s_d.bias_res = s_q.bias_res + 6'h01;
                    end
                end else begin
                    s_d.settle_cnt = s_q.settle_cnt + 5'h01;
                end
                // The last count ends the calibration and loads the ramp.
                if (s_q.cal_cnt >= cal_len - 14'h0001) begin
                    s_d.st = sctc_pkg::SCTC_RAMP;
                    s_d.pump_cur = s_q.pump[3:0];
                    s_d.step_cnt = 9'h000;
                end
            end
            sctc_pkg::SCTC_RAMP: begin
                // A new entry restarts calibration over a running ramp.
                // The ramp ends as soon as the current is at or below the
                // stop value, so a start at or below stop never steps.
                // The current then stays put until the next calibration.
                if (start_cal) begin
                    s_d.st = sctc_pkg::SCTC_CAL;
                    s_d.cal_cnt = 14'h0000;
                    s_d.settle_cnt = 5'h00;
                end else if (s_q.pump_cur <= s_q.pump[7:4]) begin
                    s_d.st = sctc_pkg::SCTC_IDLE;
                end else if (s_q.step_cnt >= step_len - 9'h001) begin
                    s_d.step_cnt = 9'h000;
                    s_d.pump_cur = s_q.pump_cur - 4'h1;
                end else begin
                    s_d.step_cnt = s_q.step_cnt + 9'h001;
                end
            end
            // An unused code falls back to idle rather than locking up.
            default: s_d.st = sctc_pkg::SCTC_IDLE;
        endcase
        // Read mux; results sit in the low bits of their registers.
        // Read data is registered, so it trails the index by one cycle.
        // Unmapped indices read zero so that the host sees no stale word.
        case (cfg_raddr_in)
            sctc_pkg::ADDR_GAIN_DIFF:  s_d.rdata = s_q.gain;
            sctc_pkg::ADDR_ARRAY_TEST: s_d.rdata = {s_q.arr[15:5], s_q.arr_res};
            sctc_pkg::ADDR_CAL_CFG:    s_d.rdata = s_q.cfg;
            sctc_pkg::ADDR_BIAS_TEST:  s_d.rdata = {s_q.bias[15:6], s_q.bias_res};
            sctc_pkg::ADDR_PUMP_TEST:  s_d.rdata = s_q.pump;
            default:                   s_d.rdata = 16'h0000;
        endcase
    end

    // State register; reset values come from the package.
    // The synchroniser flops advance in every branch but the reset one.
    // Everything else holds its reset value until the release is through.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q.rst_sync <= 2'b00;
            s_q.st <= sctc_pkg::SCTC_IDLE;
            s_q.gain <= sctc_pkg::RST_GAIN_DIFF;
            s_q.arr <= sctc_pkg::RST_ARRAY_TEST;
            s_q.cfg <= sctc_pkg::RST_CAL_CFG;
            s_q.bias <= sctc_pkg::RST_BIAS_TEST;
            s_q.pump <= sctc_pkg::RST_PUMP_TEST;
            s_q.arr_res <= sctc_pkg::RST_ARRAY_RES;
            s_q.bias_res <= sctc_pkg::RST_BIAS_RES;
            s_q.cal_cnt <= 14'h0000;
            s_q.settle_cnt <= 5'h00;
            s_q.step_cnt <= 9'h000;
            s_q.pump_cur <= sctc_pkg::RST_PUMP_TEST[3:0];
            s_q.rdata <= 16'h0000;
        end else if (!rst_n) begin
            // Release still in progress: shift the synchroniser and hold the state at idle.
            s_q.rst_sync <= {s_q.rst_sync[0], 1'b1};
            s_q.st <= sctc_pkg::SCTC_IDLE;
        end else begin
            // Normal operation: the second flop reads only the first.
            s_q.rst_sync <= {s_q.rst_sync[0], 1'b1};
            s_q.st <= s_d.st;
            s_q.gain <= s_d.gain;
            s_q.arr <= s_d.arr;
            s_q.cfg <= s_d.cfg;
            s_q.bias <= s_d.bias;
            s_q.pump <= s_d.pump;
            s_q.arr_res <= s_d.arr_res;
            s_q.bias_res <= s_d.bias_res;
            s_q.cal_cnt <= s_d.cal_cnt;
            s_q.settle_cnt <= s_d.settle_cnt;
            s_q.step_cnt <= s_d.step_cnt;
            s_q.pump_cur <= s_d.pump_cur;
            s_q.rdata <= s_d.rdata;
        end
    end

    // Outputs driven straight from registered state.
    // Selects between two registered values, a state decode and one gate are the only logic here.
    // Override enables win over the sequencer results at once, so an
    // override written mid-calibration takes effect on the next cycle.
    // The pump is held off only while calibrating with its disable set.
    // The current override bypasses the ramp but leaves it running.
    assign cfg_rdata_out = s_q.rdata;
    assign mid_to_high_gain_delta_out = s_q.gain[9:5];
    assign low_to_mid_gain_delta_out = s_q.gain[4:0];
    assign osc_array_out = s_q.arr[10] ? s_q.arr[9:5] : s_q.arr_res;
    assign osc_bias_a_out = s_q.bias[12] ? s_q.bias[11:6] : s_q.bias_res;
    assign osc_bias_b_out = s_q.cfg[9:4];
    assign osc_bias_reference_out = s_q.cfg[13:10];
    assign osc_bias_cal_speed_out = s_q.bias[14:13];
    assign tune_node_dac_select_out = s_q.cfg[3];
    assign tune_node_dac_value_out = s_q.cfg[2:0];
    assign cal_busy_out = (s_q.st == sctc_pkg::SCTC_CAL);
    assign pump_enable_out = !(cal_busy_out && s_q.pump[15]);
    assign pump_pulse_mask_out = s_q.pump[11];
    assign pump_force_up_out = s_q.pump[13];
    assign pump_force_down_out = s_q.pump[12];
    assign phase_det_long_delay_out = s_q.pump[10];
    assign pump_current_out = s_q.pump[14] ? s_q.pump[3:0] : s_q.pump_cur;
endmodule

/* sctc_pkg.sv */
// Package for the synthesizer calibration test control register group.
package sctc_pkg;
    // Register indices on the configuration port.
    localparam logic [5:0] ADDR_GAIN_DIFF  = 6'h26;  // Gain step difference register.
    localparam logic [5:0] ADDR_ARRAY_TEST = 6'h27;  // Oscillator array test register.
    localparam logic [5:0] ADDR_CAL_CFG    = 6'h28;  // Calibration configuration register.
    localparam logic [5:0] ADDR_BIAS_TEST  = 6'h29;  // Oscillator bias test register.
    localparam logic [5:0] ADDR_PUMP_TEST  = 6'h2a;  // Charge pump test register.
    // Reset values of the whole registers.
    localparam logic [15:0] RST_GAIN_DIFF  = 16'h012a;  // Deltas 9 and 10.
    localparam logic [15:0] RST_ARRAY_TEST = 16'h0200;  // Override value 16.
    localparam logic [15:0] RST_CAL_CFG    = 16'h5002;  // Measure double, reference 4, dac 2.
    localparam logic [15:0] RST_BIAS_TEST  = 16'h0600;  // Override value 24.
    localparam logic [15:0] RST_PUMP_TEST  = 16'h82dd;  // Interval 2, currents 13.
    localparam logic [4:0]  RST_ARRAY_RES  = 5'h10;     // Array result after reset.
    localparam logic [5:0]  RST_BIAS_RES   = 6'h20;     // Bias result after reset.
    // Writable bit masks; reserved and read-only bits are zero.
    localparam logic [15:0] WMASK_GAIN  = 16'h03ff;
    localparam logic [15:0] WMASK_ARRAY = 16'h0fe0;
    localparam logic [15:0] WMASK_BIAS  = 16'h7fc0;
    // Calibration times in ns at a 125 MHz clock.
    localparam int CLK_NS       = 8;
    localparam int CAL_SHORT_NS = 37000;
    localparam int CAL_LONG_NS  = 57000;
    localparam int CAL_SHORT_CYC = CAL_SHORT_NS / CLK_NS;
    localparam int CAL_LONG_CYC  = CAL_LONG_NS / CLK_NS;
    // Settling time after an array change, normal length.
    localparam int SETTLE_CYC = 16;
    // Ramp step periods in ns.
    localparam int STEP0_NS = 250;
    localparam int STEP1_NS = 500;
    localparam int STEP2_NS = 1000;
    localparam int STEP3_NS = 4000;
    localparam int STEP0_CYC = STEP0_NS / CLK_NS;
    localparam int STEP1_CYC = STEP1_NS / CLK_NS;
    localparam int STEP2_CYC = STEP2_NS / CLK_NS;
    localparam int STEP3_CYC = STEP3_NS / CLK_NS;
    // Calibration sequencer states, Gray coded.
    typedef enum logic [1:0] {
        SCTC_IDLE   = 2'b00,
        SCTC_CAL    = 2'b01,
        SCTC_RAMP   = 2'b11
    } sctc_state_e;
    // Register write request from the configuration port.
    typedef struct packed {
        logic        wr;
        logic [5:0]  addr;
        logic [15:0] data;
    } sctc_wr_s;
    // All state of the block.
    typedef struct packed {
        logic [1:0]  rst_sync;
        sctc_state_e st;
        logic [15:0] gain;
        logic [15:0] arr;
        logic [15:0] cfg;
        logic [15:0] bias;
        logic [15:0] pump;
        logic [4:0]  arr_res;
        logic [5:0]  bias_res;
        logic [13:0] cal_cnt;
        logic [4:0]  settle_cnt;
        logic [8:0]  step_cnt;
        logic [3:0]  pump_cur;
        logic [15:0] rdata;
    } sctc_state_s;
endpackage

/* sctc_host_model.sv */
// Host model that drives the register write and read port.
`timescale 1ns/100ps
module sctc_host_model (
    input  wire logic         clk_in,    // Device clock.
    input  wire logic [15:0]  rdata_in,  // Read data from the device.
    output sctc_pkg::sctc_wr_s wr_out,   // Write request.
    output logic [5:0]        raddr_out  // Read index.
);
    // Mask of bits the host may set; reserved bits always go out as zero.
    function automatic logic [15:0] keep(input logic [5:0] a);
        case (a)
            sctc_pkg::ADDR_GAIN_DIFF:  keep = 16'h03ff;
            sctc_pkg::ADDR_ARRAY_TEST: keep = 16'h0fff;
            sctc_pkg::ADDR_BIAS_TEST:  keep = 16'h7fff;
            default:                   keep = 16'hffff;
        endcase
    endfunction
    // Bus starts idle.
    initial begin
        wr_out = '0;
        raddr_out = 6'h00;
    end
    // One write, held across exactly one rising edge.
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk_in);
        wr_out = {1'b1, a, d & keep(a)};
        @(negedge clk_in);
        wr_out.wr = 1'b0;
        // Released data must not look like a valid word.
        wr_out.data = ~wr_out.data;
    endtask
    // Read: the index is sampled at one edge and data is taken after it.
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(negedge clk_in);
        raddr_out = a;
        @(negedge clk_in);
        d = rdata_in;
    endtask
endmodule

/* sctc_ctrl_assertions.sv */
// Concurrent checks on the calibration test control ports.
`timescale 1ns/100ps
module sctc_ctrl_assertions (
    input wire logic               sys_clk_in,   // Clock.
    input wire logic               reset_n_in,   // Reset, active low.
    input wire sctc_pkg::sctc_wr_s cfg_wr_in,    // Write request.
    input wire logic [4:0]         mid_to_high_gain_delta_out, // Delta.
    input wire logic [4:0]         low_to_mid_gain_delta_out,  // Delta.
    input wire logic [4:0]         osc_array_out,   // Array setting.
    input wire logic [5:0]         osc_bias_a_out,  // First bias.
    input wire logic [5:0]         osc_bias_b_out,  // Second bias.
    input wire logic [3:0]         osc_bias_reference_out, // Reference.
    input wire logic [1:0]         osc_bias_cal_speed_out, // Speed.
    input wire logic               tune_node_dac_select_out, // Dac select.
    input wire logic [2:0]         tune_node_dac_value_out,  // Dac value.
    input wire logic               cal_busy_out,    // Calibrating.
    input wire logic               pump_enable_out, // Pump enabled.
    input wire logic               pump_pulse_mask_out,  // Mask.
    input wire logic               pump_force_up_out,    // Force up.
    input wire logic               pump_force_down_out,  // Force down.
    input wire logic               phase_det_long_delay_out, // Delay.
    input wire logic [3:0]         pump_current_out // Pump current.
);
    logic [5:0]  wa; // Written index, zero when no write.
    logic [15:0] wd; // Written data.
    assign wa = cfg_wr_in.wr ? cfg_wr_in.addr : 6'h00;
    assign wd = cfg_wr_in.data;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_gain; wa == 6'h26 |=> mid_to_high_gain_delta_out == $past(wd[9:5])
        && low_to_mid_gain_delta_out == $past(wd[4:0]); endproperty
    a_gain: assert property (p_gain) else $error("gain delta mismatch");
    property p_arr; wa == 6'h27 && wd[10] |=> osc_array_out == $past(wd[9:5]); endproperty
    a_arr: assert property (p_arr) else $error("array override ignored");
    property p_dac; wa == 6'h28 |=> tune_node_dac_select_out == $past(wd[3])
        && tune_node_dac_value_out == $past(wd[2:0]); endproperty
    a_dac: assert property (p_dac) else $error("tune dac mismatch");
    property p_ref; wa == 6'h28 |=> osc_bias_reference_out == $past(wd[13:10])
        && osc_bias_b_out == $past(wd[9:4]); endproperty
    a_ref: assert property (p_ref) else $error("bias reference mismatch");
    property p_spd; wa == 6'h29 |=> osc_bias_cal_speed_out == $past(wd[14:13]); endproperty
    a_spd: assert property (p_spd) else $error("bias speed mismatch");
    property p_bov; wa == 6'h29 && wd[12] |=> osc_bias_a_out == $past(wd[11:6]); endproperty
    a_bov: assert property (p_bov) else $error("bias override ignored");
    property p_cov; wa == 6'h2a && wd[14] |=> pump_current_out == $past(wd[3:0]); endproperty
    a_cov: assert property (p_cov) else $error("pump override ignored");
    property p_pbit; wa == 6'h2a |=> {pump_force_up_out, pump_force_down_out,
        pump_pulse_mask_out, phase_det_long_delay_out} == $past(wd[13:10]); endproperty
    a_pbit: assert property (p_pbit) else $error("pump test bits mismatch");
    property p_poff; !pump_enable_out |-> cal_busy_out; endproperty
    a_poff: assert property (p_poff) else $error("pump off outside calibration");
endmodule
bind sctc_ctrl sctc_ctrl_assertions sctc_ctrl_assertions_i (.sys_clk_in, .reset_n_in,
    .cfg_wr_in, .mid_to_high_gain_delta_out, .low_to_mid_gain_delta_out, .osc_array_out,
    .osc_bias_a_out, .osc_bias_b_out, .osc_bias_reference_out, .osc_bias_cal_speed_out,
    .tune_node_dac_select_out, .tune_node_dac_value_out, .cal_busy_out, .pump_enable_out,
    .pump_pulse_mask_out, .pump_force_up_out, .pump_force_down_out,
    .phase_det_long_delay_out, .pump_current_out);

/* test_synth_calibration_test_control.sv */
// Self-checking bench for the calibration test control registers.
`timescale 1ns/100ps
module test_synth_calibration_test_control;
    logic sys_clk_in = 1'b0; // 125 MHz clock.
    logic reset_n_in = 1'b0; // Reset, active low.
    logic rx_in = 1'b0, tx_in = 1'b0, stb_in = 1'b0, fh_in = 1'b0, bh_in = 1'b0;
    sctc_pkg::sctc_wr_s wr;  // Write request from the host.
    logic [5:0]  raddr, a;   // Read index and scratch index.
    logic [15:0] rdata, d, got;
    logic [4:0]  arr;
    logic [5:0]  ba;
    logic        busy, pen;
    logic [3:0]  pcur;
    int fails = 0, num_checks = 0, cyc = 0, seed = 48, n;
    logic [15:0] rst_v [5] = '{16'h012a, 16'h0210, 16'h5002, 16'h0620, 16'h82dd};
    always #4 sys_clk_in = ~sys_clk_in;
    // Comparator levels wander at random so the search logic is exercised.
    always @(negedge sys_clk_in) {fh_in, bh_in} <= 2'($random(seed));
    sctc_ctrl sctc_ctrl_i (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cfg_wr_in(wr),
        .cfg_raddr_in(raddr), .rx_entry_in(rx_in), .tx_entry_in(tx_in),
        .tx_cal_strobe_in(stb_in), .vco_freq_high_in(fh_in), .bias_high_in(bh_in),
        .cfg_rdata_out(rdata), .mid_to_high_gain_delta_out(), .low_to_mid_gain_delta_out(),
        .osc_array_out(arr), .osc_bias_a_out(ba), .osc_bias_b_out(),
        .osc_bias_reference_out(), .osc_bias_cal_speed_out(), .tune_node_dac_select_out(),
        .tune_node_dac_value_out(), .cal_busy_out(busy), .pump_enable_out(pen),
        .pump_pulse_mask_out(), .pump_force_up_out(), .pump_force_down_out(),
        .phase_det_long_delay_out(), .pump_current_out(pcur));
    sctc_host_model sctc_host_model_i (.clk_in(sys_clk_in), .rdata_in(rdata),
        .wr_out(wr), .raddr_out(raddr));
    // Read-back value: reserved bits read zero, result fields keep reset values.
    function automatic logic [15:0] expv(input logic [5:0] ad, input logic [15:0] dv);
        case (ad)
            6'h26:   expv = dv & 16'h03ff;
            6'h27:   expv = (dv & 16'h0fe0) | 16'h0010;
            6'h29:   expv = (dv & 16'h7fc0) | 16'h0020;
            default: expv = dv;
        endcase
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One-cycle start pulse: 0 receive entry, 1 transmit entry, 2 strobe.
    task automatic pulse(input int k);
        @(negedge sys_clk_in);
        {rx_in, tx_in, stb_in} = 3'b100 >> k;
        @(negedge sys_clk_in);
        {rx_in, tx_in, stb_in} = 3'b000;
    endtask
    // Waits out a calibration and checks its length to within two cycles.
    task automatic cal_len(input int len);
        n = 0;
        while (busy !== 1'b1 && n < 4) begin @(negedge sys_clk_in); n++; end
        chk(pen, 1'b0);
        n = 0;
        while (busy === 1'b1 && n < 8000) begin @(negedge sys_clk_in); n++; end
        chk(16'(n > len - 3 && n < len + 3), 16'h0001);
    endtask
    task automatic final_report;
        if (fails == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Cuts a hang short well beyond the three calibrations.
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin fails++; final_report; end
    end
    initial begin
        repeat (5) @(negedge sys_clk_in);
        reset_n_in = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        for (int i = 0; i < 5; i++) begin
            sctc_host_model_i.rd(6'h26 + 6'(i), got);
            chk(got, rst_v[i]);
        end
        sctc_host_model_i.rd(6'h2b, got);
        chk(got, 16'h0000);
        chk(arr, 5'h10);
        chk(ba, 6'h20);
        chk(pcur, 4'hd);
        // Random words to randomly picked registers of the five, read straight back.
        for (int i = 0; i < 24; i++) begin
            a = 6'h26 + 6'(($random(seed) & 7) % 5);
            d = 16'($random(seed));
            sctc_host_model_i.wr(a, d);
            sctc_host_model_i.rd(a, got);
            chk(got, expv(a, d));
        end
        sctc_host_model_i.wr(6'h2a, 16'h8069);
        sctc_host_model_i.wr(6'h28, 16'hd002);
        pulse(1);
        repeat (4) @(negedge sys_clk_in);
        chk(busy, 1'b0);
        pulse(2);
        cal_len(sctc_pkg::CAL_LONG_CYC);
        repeat (2) @(negedge sys_clk_in);
        chk(pcur, 4'h9);
        n = 2;
        while (pcur === 4'h9 && n < 100) begin @(negedge sys_clk_in); n++; end
        chk(16'(n > sctc_pkg::STEP0_CYC - 3 && n < sctc_pkg::STEP0_CYC + 3), 16'h1);
        chk(pcur, 4'h8);
        repeat (150) @(negedge sys_clk_in);
        chk(pcur, 4'h6);
        // Start below stop must hold the start current.
        sctc_host_model_i.wr(6'h2a, 16'h8053);
        sctc_host_model_i.wr(6'h28, 16'h1002);
        pulse(1);
        cal_len(sctc_pkg::CAL_SHORT_CYC);
        repeat (150) @(negedge sys_clk_in);
        chk(pcur, 4'h3);
        pulse(0);
        cal_len(sctc_pkg::CAL_SHORT_CYC);
        final_report;
    end
endmodule
